// ==== pkg/xmi_map.vh ====
// Constants for the external parallel memory interface
`ifndef XMI_MAP_VH
`define XMI_MAP_VH
`define XMI_AW 16
`define XMI_DW 16
`define XMI_GLOBAL_BIT 15
`define XMI_EXT_DATA_TOP 16'h7fff
`define XMI_WAIT_W 3
`define XMI_GLOBAL_REGION_REGISTER_RESET 8'h00
`define XMI_OP_NONE 2'h0
`define XMI_OP_WRITE 2'h1
`define XMI_OP_READ 2'h2
`define XMI_OP_FETCH 2'h3
`endif

// ==== src/xmi_arbiter.v ====
// Fixed-priority picker for the three core requests
`timescale 1ns/1ps
`default_nettype none
`include "xmi_map.vh"
module xmi_arbiter (
  // Pending requests
  input wire write_pend,
  input wire read_pend,
  input wire fetch_pend,
  // Chosen operation
  output reg [1:0] pick
);
  always @* begin
    // Write, then read, then fetch
    if (write_pend) begin
      pick = `XMI_OP_WRITE;
    end else if (read_pend) begin
      pick = `XMI_OP_READ;
    end else if (fetch_pend) begin
      pick = `XMI_OP_FETCH;
    end else begin
      pick = `XMI_OP_NONE;
    end
  end
endmodule
`default_nettype wire

// ==== src/xmi_decode.v ====
// Address decode: off-chip and global classification
`timescale 1ns/1ps
`default_nettype none
`include "xmi_map.vh"
module xmi_decode (
  // Access
  input wire [1:0] op,
  input wire is_io,
  input wire [15:0] addr,
  // On-chip enables
  input wire onchip_prog_hit,
  input wire onchip_data_hit,
  input wire [7:0] global_region_register,
  // Result
  output wire external,
  output wire global
);
  wire data_op;
  wire upper_half;
  wire ext_prog;
  wire ext_data;
  assign data_op = (op == `XMI_OP_WRITE) || (op == `XMI_OP_READ);
  assign upper_half = addr[`XMI_GLOBAL_BIT];
  // Register granularity: each set bit maps an upper 4K block as global
  assign global = data_op && !is_io && upper_half
    && global_region_register[addr[14:12]];
  // On-chip hits stay on chip, but an I/O access goes out even on a data hit
  assign ext_prog = (op == `XMI_OP_FETCH) && !onchip_prog_hit;
  // Local data reaches only the low 32K; upper local is peripheral space
  assign ext_data = data_op && (is_io || (!onchip_data_hit
    && (global || addr <= `XMI_EXT_DATA_TOP)));
  assign external = ext_prog || ext_data;
endmodule
`default_nettype wire

// ==== src/xmi_core.v ====
// External bus sequencer of the parallel memory interface
`timescale 1ns/1ps
`default_nettype none
`include "xmi_map.vh"
module xmi_core #(
  parameter WAIT_W = `XMI_WAIT_W
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Core requests, held until done pulses
  input wire write_req,
  input wire [15:0] write_addr,
  input wire [15:0] write_data,
  input wire write_io,
  input wire read_req,
  input wire [15:0] read_addr,
  input wire read_io,
  input wire fetch_req,
  input wire [15:0] fetch_addr,
  // On-chip map state
  input wire onchip_prog_hit,
  input wire onchip_data_hit,
  input wire [7:0] global_region_register,
  input wire [WAIT_W-1:0] soft_wait,
  // Core answers
  output reg write_done,
  output reg read_done,
  output reg [15:0] read_data,
  output reg fetch_done,
  output reg [15:0] fetch_data,
  output wire stall,
  // External pins
  output reg [15:0] ext_addr,
  output reg [15:0] ext_data_out,
  output reg ext_data_oe,
  input wire [15:0] ext_data_in,
  output reg program_space_select_n,
  output reg data_space_select_n,
  output reg io_space_select_n,
  output reg read_not_write,
  output reg external_cycle_strobe_n,
  output reg global_access_request_n,
  input wire ready
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WR1 = 2'h1;
  localparam ST_ACC = 2'h2;
  localparam ST_WAIT = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg ready_s1;
  reg ready_s2;
  reg [15:0] din_s1;
  reg [15:0] din_s2;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ready_s1 <= 1'b0;
      ready_s2 <= 1'b0;
      din_s1 <= 16'h0000;
      din_s2 <= 16'h0000;
    end else begin
      ready_s1 <= ready;
      ready_s2 <= ready_s1;
      din_s1 <= ext_data_in;
      din_s2 <= din_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Selection of the next operation
  wire [1:0] pick;
  reg [1:0] op;
  reg [1:0] state;
  reg [WAIT_W-1:0] wait_cnt;
  reg [1:0] sync_hold;
  wire ext;
  wire glb;
  wire busy;
  wire [15:0] sel_addr;
  wire sel_io;
  assign busy = (state != ST_IDLE);
  // Done pulses drop the request one cycle later, so mask retired ones
  xmi_arbiter u_arb (
    .write_pend(write_req && !write_done),
    .read_pend(read_req && !read_done),
    .fetch_pend(fetch_req && !fetch_done),
    .pick(pick)
  );
  function [15:0] addr_of;
    input [1:0] o;
    input [15:0] wa;
    input [15:0] ra;
    input [15:0] fa;
    begin
      case (o)
        `XMI_OP_WRITE: addr_of = wa;
        `XMI_OP_READ: addr_of = ra;
        default: addr_of = fa;
      endcase
    end
  endfunction
  assign sel_addr = addr_of(pick, write_addr, read_addr, fetch_addr);
  assign sel_io = (pick == `XMI_OP_WRITE) ? write_io
    : ((pick == `XMI_OP_READ) ? read_io : 1'b0);
  xmi_decode u_dec (
    .op(pick),
    .is_io(sel_io),
    .addr(sel_addr),
    .onchip_prog_hit(onchip_prog_hit),
    .onchip_data_hit(onchip_data_hit),
    .global_region_register(global_region_register),
    .external(ext),
    .global(glb)
  );
  // Core waits whenever any external cycle is open
  assign stall = busy || (pick != `XMI_OP_NONE && ext);

  ////////////////////////////////////////////////////////////////////////
  // Bus sequencer
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      op <= `XMI_OP_NONE;
      wait_cnt <= {WAIT_W{1'b0}};
      sync_hold <= 2'h0;
      write_done <= 1'b0;
      read_done <= 1'b0;
      fetch_done <= 1'b0;
      read_data <= 16'h0000;
      fetch_data <= 16'h0000;
      ext_addr <= 16'h0000;
      ext_data_out <= 16'h0000;
      ext_data_oe <= 1'b0;
      program_space_select_n <= 1'b1;
      data_space_select_n <= 1'b1;
      io_space_select_n <= 1'b1;
      read_not_write <= 1'b1;
      external_cycle_strobe_n <= 1'b1;
      global_access_request_n <= 1'b1;
    end else begin
      write_done <= 1'b0;
      read_done <= 1'b0;
      fetch_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (pick != `XMI_OP_NONE && !ext) begin
            // Internal access completes without a bus cycle
            write_done <= (pick == `XMI_OP_WRITE);
            read_done <= (pick == `XMI_OP_READ);
            fetch_done <= (pick == `XMI_OP_FETCH);
          end else if (pick != `XMI_OP_NONE) begin
            op <= pick;
            ext_addr <= sel_addr;
            program_space_select_n <= !(pick == `XMI_OP_FETCH);
            data_space_select_n <= !(pick != `XMI_OP_FETCH && !sel_io);
            io_space_select_n <= !sel_io;
            read_not_write <= (pick != `XMI_OP_WRITE);
            global_access_request_n <= !glb;
            external_cycle_strobe_n <= 1'b0;
            wait_cnt <= soft_wait;
            sync_hold <= 2'h2;
            if (pick == `XMI_OP_WRITE) begin
              ext_data_out <= write_data;
              ext_data_oe <= 1'b1;
              state <= ST_WR1;
            end else begin
              state <= ST_ACC;
            end
          end
        end
        ST_WR1: begin
          // Extra write cycle gives the bus its turnaround margin
          state <= ST_ACC;
        end
        ST_ACC, ST_WAIT: begin
          // Programmed waits first, so each one adds a whole cycle
          if (wait_cnt != {WAIT_W{1'b0}}) begin
            wait_cnt <= wait_cnt - 1'b1;
            state <= ST_WAIT;
          end else if (sync_hold != 2'h0) begin
            // Pins lag two flops; stale ready or data must not pass
            sync_hold <= sync_hold - 2'h1;
            state <= ST_WAIT;
          end else if (!ready_s2) begin
            state <= ST_WAIT;
          end else begin
            if (op == `XMI_OP_READ) begin
              read_data <= din_s2;
            end
            if (op == `XMI_OP_FETCH) begin
              fetch_data <= din_s2;
            end
            write_done <= (op == `XMI_OP_WRITE);
            read_done <= (op == `XMI_OP_READ);
            fetch_done <= (op == `XMI_OP_FETCH);
            state <= ST_IDLE;
            external_cycle_strobe_n <= 1'b1;
            ext_data_oe <= 1'b0;
            global_access_request_n <= 1'b1;
            read_not_write <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== test/xmi_core_monitor.sv ====
// Pin protocol checker for the external bus sequencer
`timescale 1ns/1ps
`default_nettype none
module xmi_core_monitor #(
  parameter WAIT_W = 3
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Core side
  input wire [WAIT_W-1:0] soft_wait,
  input wire read_done,
  input wire write_done,
  input wire fetch_done,
  // Pins
  input wire [15:0] ext_addr,
  input wire ext_data_oe,
  input wire program_space_select_n,
  input wire data_space_select_n,
  input wire io_space_select_n,
  input wire read_not_write,
  input wire external_cycle_strobe_n,
  input wire global_access_request_n,
  input wire ready
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  wire external_cycle_strobe = !external_cycle_strobe_n;
  wire any_done = read_done | write_done | fetch_done;
  // Data read opening with ready high on both edges
  sequence quick_read_s;
    $fell(external_cycle_strobe_n) && read_not_write && program_space_select_n
      && ready && soft_wait == 0 ##1 ready;
  endsequence
  space_sel_a: assert property (external_cycle_strobe |-> !(program_space_select_n
    & data_space_select_n & io_space_select_n)) else $error("strobe without space");
  global_map_a: assert property (external_cycle_strobe && !data_space_select_n |->
    global_access_request_n == !ext_addr[15]) else $error("global request wrong");
  global_only_a: assert property (!global_access_request_n |->
    !data_space_select_n && ext_addr[15]) else $error("stray global request");
  io_alone_a: assert property (!io_space_select_n |-> program_space_select_n
    && data_space_select_n && global_access_request_n) else $error("io select mixed");
  fetch_read_a: assert property (!program_space_select_n |-> read_not_write)
    else $error("fetch not a read");
  drive_write_a: assert property (ext_data_oe |-> !read_not_write)
    else $error("driving bus on read");
  write_len_a: assert property ($fell(external_cycle_strobe_n) && !read_not_write |=> external_cycle_strobe)
    else $error("write shorter than two cycles");
  addr_hold_a: assert property (external_cycle_strobe ##1 external_cycle_strobe |-> $stable(ext_addr))
    else $error("address moved in cycle");
  wait_hold_a: assert property ((!ready && external_cycle_strobe)[*4] |-> !any_done)
    else $error("finished while not ready");
  quick_read_a: assert property (quick_read_s |-> ##2 read_done)
    else $error("read not zero wait");
endmodule
bind xmi_core xmi_core_monitor #(.WAIT_W(WAIT_W)) xmi_core_monitor_inst (.*);
`default_nettype wire

// ==== test/xmi_far_mem.sv ====
// External memory model answering on the parallel bus
`timescale 1ns/1ps
`default_nettype none
module xmi_far_mem (
  // Bus pins
  input wire clock,
  input wire [15:0] ext_addr,
  input wire [15:0] ext_data_out,
  input wire ext_data_oe,
  input wire read_not_write,
  input wire external_cycle_strobe_n,
  output logic [15:0] ext_data_in,
  output logic ready,
  // Slowness in cycles
  input wire [7:0] waits
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  int cnt = 0;
  // Idle bus toggles so a stale word never passes
  assign ext_data_in = (!external_cycle_strobe_n && read_not_write) ? mem[ext_addr[7:0]] : ~last;
  // Ready low until the slow access has finished
  assign ready = external_cycle_strobe_n ? (waits == 0) : (cnt >= waits);
  always @(posedge clock) begin
    cnt <= external_cycle_strobe_n ? 0 : cnt + 1;
    last <= ext_data_in;
    if (!external_cycle_strobe_n && ext_data_oe)
      mem[ext_addr[7:0]] <= ext_data_out;
  end
endmodule
`default_nettype wire

// ==== test/external_parallel_memory_interface_bench.sv ====
// Self-checking bench for the external bus sequencer
`timescale 1ns/1ps
`default_nettype none
module external_parallel_memory_interface_bench;
  logic clock = 0, rst = 1, ready, write_req = 0, read_req = 0, fetch_req = 0;
  logic write_io = 0, read_io = 0, onchip_prog_hit = 0, onchip_data_hit = 0, external_cycle_strobe_q = 1;
  logic [15:0] write_addr = 0, write_data = 0, read_addr = 0, fetch_addr = 0, ext_data_in;
  logic [15:0] read_data, fetch_data, ext_addr, ext_data_out;
  logic [7:0] global_region_register = 0, waits = 0;
  logic [2:0] soft_wait = 0;
  logic write_done, read_done, fetch_done, stall, ext_data_oe, program_space_select_n;
  logic data_space_select_n, io_space_select_n, read_not_write, external_cycle_strobe_n;
  logic global_access_request_n;
  logic [3:0] log [$];
  int n_fail = 0, comparisons = 0, nlow, gseen, nstall;
  initial forever #25 clock = ~clock;
  xmi_core xmi_core_inst (.*);
  xmi_far_mem xmi_far_mem_inst (.*);
  always @(posedge clock) begin
    if (!external_cycle_strobe_n && external_cycle_strobe_q)
      log.push_back({read_not_write, program_space_select_n, data_space_select_n,
        io_space_select_n});
    nlow += !external_cycle_strobe_n;
    gseen += !global_access_request_n;
    nstall += stall;
    external_cycle_strobe_q <= external_cycle_strobe_n;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Requests held until their done pulse, dropped the cycle after
  task xfer(input logic [2:0] rq, input logic [15:0] a, input logic [15:0] d, input logic io);
    logic [2:0] pend;
    int cyc;
    log.delete();
    nlow = 0;
    gseen = 0;
    nstall = 0;
    pend = rq;
    cyc = 0;
    @(posedge clock);
    {write_req, read_req, fetch_req} <= rq;
    write_addr <= a;
    read_addr <= a;
    fetch_addr <= a;
    write_data <= d;
    write_io <= io;
    read_io <= io;
    while (pend != 0 && cyc < 200) begin
      @(posedge clock);
      cyc++;
      pend = pend & ~{write_done, read_done, fetch_done};
      {write_req, read_req, fetch_req} <= pend;
    end
    chk("requests retired", 16'h0000, pend);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_rw;
    xfer(3'b100, 16'h0123, 16'h5a3c, 0);
    chk("write space", 4'b0101, log[0]);
    chk("write length", 4, nlow);
    xfer(3'b010, 16'h0123, 16'h0000, 0);
    chk("read data", 16'h5a3c, read_data);
    chk("read length", 3, nlow);
    chk("read stall", 4, nstall);
    $display("t_rw done");
  endtask
  task t_io;
    xfer(3'b100, 16'hff07, 16'hc3a5, 1);
    chk("io write space", 4'b0110, log[0]);
    xfer(3'b010, 16'hff07, 16'h0000, 1);
    chk("io read space", 4'b1110, log[0]);
    chk("io read data", 16'hc3a5, read_data);
    $display("t_io done");
  endtask
  task t_order;
    xfer(3'b111, 16'h0040, 16'h1111, 0);
    chk("first op", 4'b0101, log[0]);
    chk("second op", 4'b1101, log[1]);
    chk("third op", 4'b1011, log[2]);
    chk("read after write", 16'h1111, read_data);
    chk("fetch data", 16'h1111, fetch_data);
    $display("t_order done");
  endtask
  task t_wait;
    waits <= 8'h07;
    xfer(3'b010, 16'h0123, 16'h0000, 0);
    chk("slow length", 10, nlow);
    chk("slow data", 16'h5a3c, read_data);
    waits <= 8'h00;
    soft_wait <= 3'h3;
    xfer(3'b010, 16'h0123, 16'h0000, 0);
    chk("soft length", 6, nlow);
    soft_wait <= 3'h0;
    $display("t_wait done");
  endtask
  task t_map;
    global_region_register <= 8'h01;
    xfer(3'b010, 16'h8004, 16'h0000, 0);
    chk("global seen", 1, gseen > 0);
    chk("global space", 4'b1101, log[0]);
    global_region_register <= 8'h00;
    xfer(3'b010, 16'h8004, 16'h0000, 0);
    chk("local upper cycles", 0, log.size());
    onchip_data_hit <= 1;
    xfer(3'b010, 16'h0010, 16'h0000, 0);
    chk("on chip cycles", 0, log.size());
    chk("on chip stall", 0, nstall);
    onchip_data_hit <= 0;
    onchip_prog_hit <= 1;
    xfer(3'b001, 16'h0040, 16'h0000, 0);
    chk("on chip fetch cycles", 0, log.size());
    onchip_prog_hit <= 0;
    $display("t_map done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    t_rw;
    t_io;
    t_order;
    t_wait;
    t_map;
    wrap_up;
  end
endmodule
`default_nettype wire
